// [design/tsp_pkg.sv]
// Shared constants of the trace serial port
package tsp_pkg;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_TRACE_BYTE = 3'h0;
  localparam logic [2:0] OFS_CONTROL = 3'h4;

  // ==========================================================
  // Control field positions
  localparam int CTRL_EN_POS = 0;
  localparam int CTRL_EDGE_POS = 1;
  localparam int CTRL_RATE_LSB = 2;
  localparam int CTRL_GAP_LSB = 4;

  // ==========================================================
  // Reset values
  localparam logic [7:0] TRACE_BYTE_RST = 8'h00;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic CTRL_EDGE_RST = 1'b0;
  localparam logic [1:0] CTRL_RATE_RST = 2'h0;
  localparam logic [2:0] CTRL_GAP_RST = 3'h0;

  // ==========================================================
  // Timing
  localparam int SYS_CLK_HZ = 48_000_000;
  localparam int RATE_FAST_HZ = 24_000_000;
  localparam int RATE_MID_HZ = 12_000_000;
  localparam int RATE_SLOW_HZ = 6_000_000;
  localparam int HALF_W = 3;
  localparam logic [HALF_W-1:0] HALF_FAST = HALF_W'(SYS_CLK_HZ / (2 * RATE_FAST_HZ));
  localparam logic [HALF_W-1:0] HALF_MID = HALF_W'(SYS_CLK_HZ / (2 * RATE_MID_HZ));
  localparam logic [HALF_W-1:0] HALF_SLOW = HALF_W'(SYS_CLK_HZ / (2 * RATE_SLOW_HZ));
  localparam logic [1:0] RATE_FAST = 2'h0;
  localparam logic [1:0] RATE_MID = 2'h1;
  localparam logic [1:0] RATE_SLOW = 2'h2;

  // ==========================================================
  // Frame shape
  localparam logic [4:0] STEP_LAST = 5'h10;

  typedef enum {
    TSP_IDLE,
    TSP_SHIFT,
    TSP_GAP
  } tsp_state_t;

endpackage

// [design/tsp_tick_if.sv]
// Half-period tick link between the port control and its timer
`timescale 1ns/1ns
`default_nettype none
interface tsp_tick_if;
  logic run;
  logic [tsp_pkg::HALF_W-1:0] half_cycles;
  logic tick;
  modport ctrl (output run, output half_cycles, input tick);
  modport timer (input run, input half_cycles, output tick);
endinterface // tsp_tick_if
`default_nettype wire

// [design/tsp_half_timer.sv]
// Half-period timer for the trace clock
`timescale 1ns/1ns
`default_nettype none
module tsp_half_timer (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  tsp_tick_if.timer tk
);

  logic [tsp_pkg::HALF_W-1:0] cnt;
  logic [tsp_pkg::HALF_W-1:0] next_cnt;
  logic at_end;

  // ==========================================================
  // Counter, cleared whenever the port is idle
  always_comb begin
    at_end = (cnt >= tk.half_cycles - tsp_pkg::HALF_W'(1));
    tk.tick = tk.run && at_end;
    next_cnt = cnt;
    if (!tk.run || at_end) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + tsp_pkg::HALF_W'(1);
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule // tsp_half_timer
`default_nettype wire

// [design/tsp_trace_port.sv]
// Trace serial port: registers, serializer and trace pins
`timescale 1ns/1ns
`default_nettype none

module tsp_trace_port (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_REG_REQ,
  input wire logic I_REG_WE,
  input wire logic [tsp_pkg::ADDR_W-1:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  output logic O_REG_ACK,
  output logic [7:0] O_REG_RDATA,
  input wire logic I_SLEEP_REQ,
  output logic O_SLEEP_ACK,
  output logic O_TRACE_CLK,
  output logic O_TRACE_DATA
);

  // ==========================================================
  // Declarations
  tsp_tick_if tk ();

  logic [7:0] trace_byte;
  logic [7:0] next_trace_byte;
  logic ctrl_en;
  logic next_ctrl_en;
  logic ctrl_edge;
  logic next_ctrl_edge;
  logic [1:0] ctrl_rate;
  logic [1:0] next_ctrl_rate;
  logic [2:0] ctrl_gap;
  logic [2:0] next_ctrl_gap;
  logic reg_ack;
  logic next_reg_ack;
  logic [7:0] reg_rdata;
  logic [7:0] next_reg_rdata;

  tsp_pkg::tsp_state_t state;
  tsp_pkg::tsp_state_t next_state;
  logic [4:0] step;
  logic [4:0] next_step;
  logic [4:0] gap_cnt;
  logic [4:0] next_gap_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic clk_q;
  logic next_clk_q;
  logic dat_q;
  logic next_dat_q;

  logic accept;
  logic wr_byte;
  logic wr_ctrl;
  logic hold_off;
  logic start;
  logic [4:0] step_inc;
  logic [4:0] gap_last;
  logic [7:0] ctrl_view;

  // ==========================================================
  // Timer hookup
  tsp_half_timer u_timer (
    .I_CLK(I_CLK),
    .I_ARST_N(I_ARST_N),
    .tk(tk)
  );

  assign tk.run = (state != tsp_pkg::TSP_IDLE);

  always_comb begin
    case (ctrl_rate)
      tsp_pkg::RATE_FAST: tk.half_cycles = tsp_pkg::HALF_FAST;
      tsp_pkg::RATE_MID: tk.half_cycles = tsp_pkg::HALF_MID;
      tsp_pkg::RATE_SLOW: tk.half_cycles = tsp_pkg::HALF_SLOW;
      // Reserved code runs at the slowest rate
      default: tk.half_cycles = tsp_pkg::HALF_SLOW;
    endcase
  end

  // ==========================================================
  // Register access
  // write hold-off
  assign hold_off = I_REG_WE && (I_REG_ADDR == tsp_pkg::OFS_TRACE_BYTE) &&
                    (state != tsp_pkg::TSP_IDLE);
  assign accept = I_REG_REQ && !reg_ack && !hold_off;
  assign wr_byte = accept && I_REG_WE && (I_REG_ADDR == tsp_pkg::OFS_TRACE_BYTE);
  assign wr_ctrl = accept && I_REG_WE && (I_REG_ADDR == tsp_pkg::OFS_CONTROL);

  // start only when enabled and awake
  assign start = wr_byte && ctrl_en && !I_SLEEP_REQ;

  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[tsp_pkg::CTRL_EN_POS] = ctrl_en;
    ctrl_view[tsp_pkg::CTRL_EDGE_POS] = ctrl_edge;
    ctrl_view[tsp_pkg::CTRL_RATE_LSB +: 2] = ctrl_rate;
    ctrl_view[tsp_pkg::CTRL_GAP_LSB +: 3] = ctrl_gap;
  end

  always_comb begin
    next_trace_byte = trace_byte;
    next_ctrl_en = ctrl_en;
    next_ctrl_edge = ctrl_edge;
    next_ctrl_rate = ctrl_rate;
    next_ctrl_gap = ctrl_gap;
    next_reg_ack = accept;
    next_reg_rdata = reg_rdata;
    if (wr_byte) begin
      next_trace_byte = I_REG_WDATA;
    end
    if (wr_ctrl) begin
      next_ctrl_en = I_REG_WDATA[tsp_pkg::CTRL_EN_POS];
      next_ctrl_edge = I_REG_WDATA[tsp_pkg::CTRL_EDGE_POS];
      next_ctrl_rate = I_REG_WDATA[tsp_pkg::CTRL_RATE_LSB +: 2];
      next_ctrl_gap = I_REG_WDATA[tsp_pkg::CTRL_GAP_LSB +: 3];
    end
    if (accept && !I_REG_WE) begin
      case (I_REG_ADDR)
        tsp_pkg::OFS_TRACE_BYTE: next_reg_rdata = trace_byte;
        tsp_pkg::OFS_CONTROL: next_reg_rdata = ctrl_view;
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      trace_byte <= tsp_pkg::TRACE_BYTE_RST;
      ctrl_en <= tsp_pkg::CTRL_EN_RST;
      ctrl_edge <= tsp_pkg::CTRL_EDGE_RST;
      ctrl_rate <= tsp_pkg::CTRL_RATE_RST;
      ctrl_gap <= tsp_pkg::CTRL_GAP_RST;
      reg_ack <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      trace_byte <= next_trace_byte;
      ctrl_en <= next_ctrl_en;
      ctrl_edge <= next_ctrl_edge;
      ctrl_rate <= next_ctrl_rate;
      ctrl_gap <= next_ctrl_gap;
      reg_ack <= next_reg_ack;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ==========================================================
  // Serializer
  // Step 0 is a lead-in half with the clock high; odd steps are the
  // low half of each trace clock period, even steps the high half.
  assign step_inc = step + 5'h01;
  // gap length in halves, minus one
  assign gap_last = {1'b0, ctrl_gap, 1'b1};

  always_comb begin
    next_state = state;
    next_step = step;
    next_gap_cnt = gap_cnt;
    next_shreg = shreg;
    next_clk_q = clk_q;
    next_dat_q = dat_q;
    case (state)
      tsp_pkg::TSP_IDLE: begin
        next_clk_q = 1'b1;
        next_dat_q = 1'b1;
        if (start) begin
          next_state = tsp_pkg::TSP_SHIFT;
          next_step = 5'h00;
          next_shreg = I_REG_WDATA;
          // falling-edge mode presents bit 0 ahead of first fall
          if (!ctrl_edge) begin
            next_dat_q = I_REG_WDATA[0];
            next_shreg = {1'b0, I_REG_WDATA[7:1]};
          end
        end
      end
      tsp_pkg::TSP_SHIFT: begin
        if (!ctrl_en) begin
          next_state = tsp_pkg::TSP_IDLE;
          next_clk_q = 1'b1;
          next_dat_q = 1'b1;
        end else if (tk.tick) begin
          if (step == tsp_pkg::STEP_LAST) begin
            next_state = tsp_pkg::TSP_GAP;
            next_gap_cnt = 5'h00;
            next_clk_q = 1'b1;
            next_dat_q = 1'b1;
          end else begin
            next_step = step_inc;
            next_clk_q = !step_inc[0];
            if ((ctrl_edge && step_inc[0]) ||
                (!ctrl_edge && !step_inc[0] && step_inc != tsp_pkg::STEP_LAST)) begin
              next_dat_q = shreg[0];
              next_shreg = {1'b0, shreg[7:1]};
            end
          end
        end
      end
      tsp_pkg::TSP_GAP: begin
        next_clk_q = 1'b1;
        next_dat_q = 1'b1;
        if (!ctrl_en) begin
          next_state = tsp_pkg::TSP_IDLE;
        end else if (tk.tick) begin
          if (gap_cnt == gap_last) begin
            next_state = tsp_pkg::TSP_IDLE;
          end else begin
            next_gap_cnt = gap_cnt + 5'h01;
          end
        end
      end
      default: begin
        next_state = tsp_pkg::TSP_IDLE;
        next_clk_q = 1'b1;
        next_dat_q = 1'b1;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state <= tsp_pkg::TSP_IDLE;
      step <= 5'h00;
      gap_cnt <= 5'h00;
      shreg <= 8'h00;
      clk_q <= 1'b1;
      dat_q <= 1'b1;
    end else begin
      state <= next_state;
      step <= next_step;
      gap_cnt <= next_gap_cnt;
      shreg <= next_shreg;
      clk_q <= next_clk_q;
      dat_q <= next_dat_q;
    end
  end

  // ==========================================================
  // Outputs
  assign O_REG_ACK = reg_ack;
  assign O_REG_RDATA = reg_rdata;
  assign O_SLEEP_ACK = I_SLEEP_REQ && (state == tsp_pkg::TSP_IDLE);
  assign O_TRACE_CLK = clk_q;
  assign O_TRACE_DATA = dat_q;

endmodule // tsp_trace_port
`default_nettype wire

// [testbench/tsp_capture_model.sv]
// Capture model of the external trace system
`timescale 1ns/1ns
`default_nettype none
module tsp_capture_model (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic trace_clk,
  input wire logic trace_data,
  input wire logic edge_sel,
  output logic [7:0] byte_out,
  output int frames,
  output int half
);
  logic clk_q;
  logic [7:0] sh;
  int nbit;
  int low;
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      clk_q = 1'b1;
      nbit = 0;
      frames = 0;
      low = 0;
      half = 0;
      byte_out = 8'h00;
    end else begin
      if (clk_q !== trace_clk && trace_clk === edge_sel) begin
        sh = {trace_data, sh[7:1]};
        nbit++;
        if (nbit == 8) begin
          nbit = 0;
          byte_out = sh;
          frames++;
        end
      end
      if (trace_clk === 1'b0) begin
        low++;
      end else if (low != 0) begin
        half = low;
        low = 0;
      end
      clk_q = trace_clk;
    end
  end
endmodule // tsp_capture_model
`default_nettype wire

// [testbench/tsp_trace_port_properties.sv]
// Checker of the trace serial port pins and register port
`timescale 1ns/1ns
`default_nettype none
module tsp_trace_port_properties (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_REG_WE,
  input wire logic [tsp_pkg::ADDR_W-1:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic O_REG_ACK,
  input wire logic I_SLEEP_REQ,
  input wire logic O_SLEEP_ACK,
  input wire logic O_TRACE_CLK,
  input wire logic O_TRACE_DATA
);
  logic q_we, q_sl, en_q;
  logic [2:0] q_addr;
  logic [7:0] q_wd, ctrl;
  // Request held over the taken edge, seen in the ack cycle
  always_ff @(posedge I_CLK) begin
    q_we <= I_REG_WE;
    q_addr <= I_REG_ADDR;
    q_wd <= I_REG_WDATA;
    q_sl <= I_SLEEP_REQ;
  end
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl <= 8'h00;
      en_q <= 1'b0;
    end else begin
      en_q <= ctrl[0];
      if (O_REG_ACK && q_we && q_addr == 3'h4) begin
        ctrl <= q_wd;
      end
    end
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  sequence s_start; O_REG_ACK && q_we && q_addr == 3'h0 && ctrl[0] && !q_sl; endsequence
  sequence s_lead_slow; O_TRACE_CLK [*4] ##1 !O_TRACE_CLK; endsequence
  property p_start_clk; s_start |-> ##[1:8] !O_TRACE_CLK; endproperty
  a_start_clk: assert property (p_start_clk) else $error("frame did not start");
  property p_lsb; s_start ##0 !ctrl[1] |-> O_TRACE_DATA == q_wd[0]; endproperty
  a_lsb: assert property (p_lsb) else $error("first bit is not bit 0");
  property p_edge1; s_start ##0 ctrl[1] |-> O_TRACE_DATA; endproperty
  a_edge1: assert property (p_edge1) else $error("data moved before falling edge");
  property p_fast; s_start ##0 ctrl[3:2] == 2'h0 |=> !O_TRACE_CLK ##1 O_TRACE_CLK; endproperty
  a_fast: assert property (p_fast) else $error("fast rate half period wrong");
  property p_slow; s_start ##0 ctrl[3:2] == 2'h2 |-> s_lead_slow; endproperty
  a_slow: assert property (p_slow) else $error("slow rate half period wrong");
  property p_dis; !ctrl[0] && !en_q |-> O_TRACE_CLK && O_TRACE_DATA; endproperty
  a_dis: assert property (p_dis) else $error("pins active while disabled");
  property p_ack; O_REG_ACK |=> !O_REG_ACK; endproperty
  a_ack: assert property (p_ack) else $error("ack longer than one cycle");
  property p_sleep; O_SLEEP_ACK |-> I_SLEEP_REQ; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep ack without request");
endmodule // tsp_trace_port_properties
bind tsp_trace_port tsp_trace_port_properties u_props (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
  .I_REG_WE(I_REG_WE), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .O_REG_ACK(O_REG_ACK),
  .I_SLEEP_REQ(I_SLEEP_REQ), .O_SLEEP_ACK(O_SLEEP_ACK), .O_TRACE_CLK(O_TRACE_CLK), .O_TRACE_DATA(O_TRACE_DATA));
`default_nettype wire

// [testbench/tsp_trace_port_tb.sv]
// Self-checking bench of the trace serial port
`timescale 1ns/1ns
`default_nettype none
module tsp_trace_port_tb;
  logic clk, rst_n, req, we, sleep, edge_sel, ack, sack, tclk, tdat;
  logic [2:0] addr;
  logic [7:0] wd, rdata, cap, b;
  int frames, half, err_total, num_checks, cyc, lat, g, h, t, f0;
  tsp_trace_port u_dut (.I_CLK(clk), .I_ARST_N(rst_n), .I_REG_REQ(req), .I_REG_WE(we), .I_REG_ADDR(addr),
    .I_REG_WDATA(wd), .O_REG_ACK(ack), .O_REG_RDATA(rdata), .I_SLEEP_REQ(sleep), .O_SLEEP_ACK(sack),
    .O_TRACE_CLK(tclk), .O_TRACE_DATA(tdat));
  tsp_capture_model u_cap (.I_CLK(clk), .I_ARST_N(rst_n), .trace_clk(tclk), .trace_data(tdat),
    .edge_sel(edge_sel), .byte_out(cap), .frames(frames), .half(half));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Request held until ack is seen, dropped in the ack cycle
  task xfer(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    req = 1'b1;
    we = w;
    addr = a;
    wd = d;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (ack !== 1'b1 && lat < 300);
    req = 1'b0;
    if (lat >= 300) chk("ack", 8'h01, 8'h00);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      complete_run;
    end
  end
  // ==========================================================
  // Test sequence
  initial begin
    rst_n = 1'b0;
    {req, we, sleep, edge_sel, addr, wd} = '0;
    err_total = 0;
    num_checks = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    xfer(1'b0, 3'h0, 8'h00);
    chk("byte reset", 8'h00, rdata);
    xfer(1'b0, 3'h4, 8'h00);
    chk("ctrl reset", 8'h00, rdata);
    xfer(1'b0, 3'h2, 8'h00);
    chk("unmapped", 8'h00, rdata);
    for (int r = 0; r < 3; r++) begin
      for (int e = 0; e < 2; e++) begin
        g = (r == 2) ? 7 : r + e;
        h = 1 << r;
        b = 8'hc3 ^ 8'(r * 16 + e * 5);
        edge_sel = e[0];
        xfer(1'b1, 3'h4, {1'b0, g[2:0], r[1:0], e[0], 1'b1});
        f0 = frames;
        xfer(1'b1, 3'h0, b);
        xfer(1'b1, 3'h0, ~b);
        t = (17 + 2 * (g + 1)) * h;
        if (lat < t - 1 || lat > t + 1) chk("stall", 8'(t), 8'(lat));
        chk("byte", b, cap);
        chk("half", 8'(h), 8'(half));
        for (int k = 0; k < 200 && frames != f0 + 2; k++) @(negedge clk);
        chk("byte two", ~b, cap);
        repeat (70) @(negedge clk);
      end
    end
    xfer(1'b1, 3'h4, 8'h00);
    f0 = frames;
    xfer(1'b1, 3'h0, 8'h3c);
    repeat (40) @(negedge clk);
    chk("disabled", 8'(f0), 8'(frames));
    chk("idle pins", 8'h03, {6'h00, tclk, tdat});
    xfer(1'b0, 3'h0, 8'h00);
    chk("byte read", 8'h3c, rdata);
    sleep = 1'b1;
    xfer(1'b1, 3'h4, 8'h01);
    xfer(1'b1, 3'h0, 8'h99);
    chk("sleep ack", 8'h01, {7'h00, sack});
    repeat (40) @(negedge clk);
    chk("asleep", 8'(f0), 8'(frames));
    sleep = 1'b0;
    xfer(1'b1, 3'h0, 8'h81);
    rst_n = 1'b0;
    @(negedge clk);
    chk("reset pins", 8'h03, {6'h00, tclk, tdat});
    rst_n = 1'b1;
    xfer(1'b0, 3'h4, 8'h00);
    chk("ctrl cleared", 8'h00, rdata);
    complete_run;
  end
endmodule // tsp_trace_port_tb
`default_nettype wire
